// File: pkg/ea_decode_pkg.sv
package ea_decode_pkg;

  // ********************************************************
  // Operand field codes
  // ********************************************************
  localparam logic [4:0] CODE_REG_LAST = 5'h07;
  localparam logic [4:0] CODE_IND_FIRST = 5'h08;
  localparam logic [4:0] CODE_POSTINC_FIRST = 5'h0C;
  localparam logic [4:0] CODE_SHORT_DISPLACEMENT_FIRST = 5'h10;
  localparam logic [4:0] CODE_LONG_DISPLACEMENT_FIRST = 5'h18;
  localparam logic [4:0] CODE_INDEX_FIRST = 5'h1C;
  localparam logic [4:0] CODE_PCREL = 5'h1E;
  localparam logic [4:0] CODE_DIRECT = 5'h1F;
  localparam logic [2:0] INDEX_REG_NUM = 3'h7;

  // ********************************************************
  // Mode cycles and register accesses
  // ********************************************************
  localparam logic [3:0] CYC_PLAIN = 4'h2;
  localparam logic [3:0] CYC_POSTINC = 4'h4;
  localparam logic [3:0] CYC_DIRECT = 4'h1;
  localparam logic [1:0] RACC_ONE = 2'h1;
  localparam logic [1:0] RACC_TWO = 2'h2;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_ONE = 2'h1;
  localparam logic [1:0] EXT_TWO = 2'h2;

  // ********************************************************
  // Width and location corrections
  // ********************************************************
  localparam logic [3:0] COR_ZERO = 4'h0;
  localparam logic [3:0] COR_ONE = 4'h1;
  localparam logic [3:0] COR_TWO = 4'h2;
  localparam logic [3:0] COR_FOUR = 4'h4;
  localparam logic [3:0] COR_EIGHT = 4'h8;
  localparam logic [2:0] ACC_ONE = 3'h1;
  localparam logic [2:0] ACC_TWO = 3'h2;
  localparam logic [2:0] ACC_FOUR = 3'h4;
  localparam logic [3:0] FETCH_INT_WORD = 4'h2;
  localparam logic [3:0] FETCH_EXT = 4'h3;

  // ********************************************************
  // Limits and sizes
  // ********************************************************
  localparam logic [23:0] IO_AREA_LAST = 24'h0000FF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} op_size_e;
  typedef enum logic [1:0] {LOC_INTERNAL, LOC_EXT16, LOC_EXT8} op_loc_e;

endpackage : ea_decode_pkg

// File: src/ea_width_cost.sv
`timescale 1ns/100ps
module ea_width_cost
  import ea_decode_pkg::*;
(
  // Operand description
  input wire logic [1:0] i_size,
  input wire logic [1:0] i_loc,
  input wire logic i_is_reg,
  input wire logic i_odd,
  // Correction
  output logic [3:0] o_cycles,
  output logic [2:0] o_accesses
);

  // ********************************************************
  // Width and alignment correction
  // ********************************************************
  wire is_byte = (i_size == 2'(SZ_BYTE));
  wire is_long = (i_size == 2'(SZ_LONG));
  wire ext_slow = (i_loc == 2'(LOC_EXT8)) || ((i_loc == 2'(LOC_EXT16)) && i_odd);
  wire ext_fast = (i_loc == 2'(LOC_EXT16)) && !i_odd;
  wire int_odd = (i_loc == 2'(LOC_INTERNAL)) && i_odd && !i_is_reg;

  always_comb begin
    if (i_is_reg || (i_loc == 2'(LOC_INTERNAL) && !i_odd)) begin
      o_cycles = COR_ZERO;
      o_accesses = is_long ? ACC_TWO : ACC_ONE;
    end else if (int_odd) begin
      o_cycles = is_byte ? COR_ZERO : (is_long ? COR_FOUR : COR_TWO);
      o_accesses = is_byte ? ACC_ONE : (is_long ? ACC_FOUR : ACC_TWO);
    end else if (ext_fast) begin
      o_cycles = is_long ? COR_TWO : COR_ONE;
      o_accesses = is_long ? ACC_TWO : ACC_ONE;
    end else if (ext_slow) begin
      o_cycles = is_byte ? COR_ONE : (is_long ? COR_EIGHT : COR_FOUR);
      o_accesses = is_byte ? ACC_ONE : (is_long ? ACC_FOUR : ACC_TWO);
    end else begin
      o_cycles = COR_ZERO;
      o_accesses = ACC_ONE;
    end
  end

endmodule : ea_width_cost

// File: src/ea_decode_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Codes 00-07 select a general register directly, memory address zero.
// - Codes 08-1F select a memory mode and produce a memory address.
// - Register codes pick byte, word or long pair by operand size.
// - Codes 0C-0F address via first four word registers, post-incremented.
// - Codes 10-17 add a one-byte signed displacement to any word register.
// - Codes 18-1B add a two-byte displacement to first four word registers.
// - Codes 1C/1D add index word register seven to register zero or one.
// - Code 1E is PC plus displacement, 1F direct; both two extension bytes.
// - Extension byte count adds to base length consumed from the queue.
// - Mode cycles: 2 plain/disp/PC, 4 post-increment/index, 1 direct.
// - Register accesses: 1 plain/disp, 2 post-increment/index, 0 PC/direct.
// - Registers and even internal addresses add no cycles.
// - Odd internal addresses: word +2, long +4 cycles.
// - Even 16-bit external: byte/word +1, long +2 cycles.
// - Odd 16-bit or 8-bit external: byte +1, word +4, long +8.
// - External accesses are stretched by each ready wait cycle between decodes.
// - Fetch adds 2 internal, 3 external per word, 3 per byte on 8-bit bus.
// - Accumulator halves: byte low 8 bits, word lower half, long both.
// - Short I/O operand reaches only addresses 0 through 0000FFH.
// - Byte immediate sign-extends to 16 bits; vectors 0-15 and 0-255.
module ea_decode_top
  import ea_decode_pkg::*;
#(
  parameter int unsigned NUM_REGS = 8
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // Decode request
  input wire logic I_DEC_VALID,
  input wire logic [4:0] I_EA_CODE,
  input wire logic [1:0] I_OP_SIZE,
  input wire logic [1:0] I_OP_LOC,
  input wire logic [2:0] I_BASE_LEN,
  input wire logic [7:0] I_BASE_CYCLES,
  input wire logic [15:0] I_EXT_BYTES,
  input wire logic [15:0] I_PC,
  // Other operand fields
  input wire logic [7:0] I_BYTE_IMMEDIATE,
  input wire logic [7:0] I_IO_OFFSET,
  input wire logic [7:0] I_VECTOR_FIELD,
  input wire logic I_VECTOR_LONG,
  input wire logic [31:0] I_ACCUM,
  // Register write port
  input wire logic I_REG_WE,
  input wire logic [2:0] I_REG_NUM,
  input wire logic [15:0] I_REG_WDATA,
  // Wait and fetch accounting
  input wire logic I_WAIT_CYCLE,
  input wire logic I_FETCH_STEP,
  // Decode results
  output logic O_VALID,
  output logic O_IS_REG,
  output logic [2:0] O_REG_SEL,
  output logic O_REG_LONG,
  output logic [15:0] O_MEM_ADDR,
  output logic [1:0] O_EXT_COUNT,
  output logic [3:0] O_INSN_LEN,
  output logic [3:0] O_MODE_CYCLES,
  output logic [1:0] O_REG_ACCESSES,
  output logic [2:0] O_MEM_ACCESSES,
  output logic [9:0] O_TOTAL_CYCLES,
  output logic [15:0] O_SIGN_EXTENDED_IMMEDIATE,
  output logic [23:0] O_IO_ADDR,
  output logic [7:0] O_VECTOR,
  output logic [31:0] O_ACCUM_OPERAND,
  output logic [9:0] O_FETCH_CYCLES
);

  // ********************************************************
  // Word register file
  // ********************************************************
  logic [15:0] word_pointer_reg_q [NUM_REGS];

  // ********************************************************
  // Mode decode
  // ********************************************************
  wire [4:0] code = I_EA_CODE;
  wire sel_reg = (code <= CODE_REG_LAST);
  wire sel_ind = !sel_reg && (code < CODE_POSTINC_FIRST);
  wire sel_postinc = (code >= CODE_POSTINC_FIRST) && (code < CODE_SHORT_DISPLACEMENT_FIRST);
  wire sel_short_displacement = (code >= CODE_SHORT_DISPLACEMENT_FIRST) && (code < CODE_LONG_DISPLACEMENT_FIRST);
  wire sel_long_displacement = (code >= CODE_LONG_DISPLACEMENT_FIRST) && (code < CODE_INDEX_FIRST);
  wire sel_index = (code >= CODE_INDEX_FIRST) && (code < CODE_PCREL);
  wire sel_pcrel = (code == CODE_PCREL);
  wire sel_direct = (code == CODE_DIRECT);
  wire [2:0] low_word_pointer_reg = {1'b0, code[1:0]};
  wire [2:0] any_ptr_num = code[2:0];
  wire [2:0] index_base = {2'b00, code[0]};
  wire [15:0] long_displacement = I_EXT_BYTES;
  wire [7:0] short_displacement = I_EXT_BYTES[7:0];
  wire [15:0] index_word_reg = word_pointer_reg_q[INDEX_REG_NUM];

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction : sext8

  function automatic logic [15:0] size_bytes(input logic [1:0] sz);
    case (sz)
      2'(SZ_BYTE): size_bytes = 16'h0001;
      2'(SZ_WORD): size_bytes = 16'h0002;
      default: size_bytes = 16'h0004;
    endcase
  endfunction : size_bytes

  // The spare size code is folded onto long so that every consumer agrees on it.
  function automatic logic size_is_long(input logic [1:0] sz);
    size_is_long = sz[1];
  endfunction : size_is_long

  wire [1:0] op_size = size_is_long(I_OP_SIZE) ? 2'(SZ_LONG) : I_OP_SIZE;
  wire op_is_byte = (op_size == 2'(SZ_BYTE));
  wire op_is_word = (op_size == 2'(SZ_WORD));

  // ********************************************************
  // Register direct selection
  // ********************************************************
  // Long operands name a register pair, so the odd half of the code is dropped.
  wire reg_long = size_is_long(op_size);
  wire [2:0] reg_sel = reg_long ? {code[2:1], 1'b0} : code[2:0];

  logic [15:0] addr_d;
  logic [1:0] ext_d;
  logic [3:0] modecyc_d;
  logic [1:0] racc_d;

  always_comb begin
    addr_d = 16'h0000;
    ext_d = EXT_NONE;
    modecyc_d = COR_ZERO;
    racc_d = 2'h0;
    if (sel_ind) begin
      addr_d = word_pointer_reg_q[low_word_pointer_reg];
      modecyc_d = CYC_PLAIN;
      racc_d = RACC_ONE;
    end else if (sel_postinc) begin
      addr_d = word_pointer_reg_q[low_word_pointer_reg];
      modecyc_d = CYC_POSTINC;
      racc_d = RACC_TWO;
    end else if (sel_short_displacement) begin
      addr_d = word_pointer_reg_q[any_ptr_num] + sext8(short_displacement);
      ext_d = EXT_ONE;
      modecyc_d = CYC_PLAIN;
      racc_d = RACC_ONE;
    end else if (sel_long_displacement) begin
      addr_d = word_pointer_reg_q[low_word_pointer_reg] + long_displacement;
      ext_d = EXT_TWO;
      modecyc_d = CYC_PLAIN;
      racc_d = RACC_ONE;
    end else if (sel_index) begin
      addr_d = word_pointer_reg_q[index_base] + index_word_reg;
      modecyc_d = CYC_POSTINC;
      racc_d = RACC_TWO;
    end else if (sel_pcrel) begin
      addr_d = I_PC + long_displacement;
      ext_d = EXT_TWO;
      modecyc_d = CYC_PLAIN;
    end else if (sel_direct) begin
      addr_d = long_displacement;
      ext_d = EXT_TWO;
      modecyc_d = CYC_DIRECT;
    end
  end

  // ********************************************************
  // Width and location correction
  // ********************************************************
  logic [3:0] cor_cycles;
  logic [2:0] cor_accesses;

  ea_width_cost u_cost (
    .i_size(op_size),
    .i_loc(sel_reg ? 2'(LOC_INTERNAL) : I_OP_LOC),
    .i_is_reg(sel_reg),
    .i_odd(addr_d[0]),
    .o_cycles(cor_cycles),
    .o_accesses(cor_accesses)
  );

  wire [9:0] total_d = 10'(I_BASE_CYCLES) + 10'(modecyc_d) + 10'(cor_cycles);
  wire [3:0] len_d = 4'(I_BASE_LEN) + 4'(ext_d);
  wire ext_operand = !sel_reg && (I_OP_LOC != 2'(LOC_INTERNAL));

  wire [15:0] accum_upper_half = I_ACCUM[31:16];
  wire [15:0] accum_lower_half = I_ACCUM[15:0];
  // Byte and word operands only see the lower half; the bits above read as zero.
  wire [31:0] accum_d = op_is_byte ? {24'h000000, accum_lower_half[7:0]} :
                        op_is_word ? {16'h0000, accum_lower_half} :
                        {accum_upper_half, accum_lower_half};

  // The fetch figures are worst case; the queue often hides them.
  wire [3:0] fetch_step = (I_OP_LOC == 2'(LOC_INTERNAL)) ? FETCH_INT_WORD : FETCH_EXT;

  // ********************************************************
  // Next values of the result registers
  // ********************************************************
  wire [15:0] mem_addr_d = sel_reg ? 16'h0000 : addr_d;
  wire [15:0] sext_d = sext8(I_BYTE_IMMEDIATE);
  wire [23:0] io_addr_d = {16'h0000, I_IO_OFFSET} & IO_AREA_LAST;
  wire [7:0] vector_d = I_VECTOR_LONG ? I_VECTOR_FIELD : {4'h0, I_VECTOR_FIELD[3:0]};
  // Waits and fetch steps only accumulate between decodes; a decode restarts both.
  wire wait_hit = !I_DEC_VALID && I_WAIT_CYCLE && ext_operand;
  wire fetch_hit = !I_DEC_VALID && I_FETCH_STEP;

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        word_pointer_reg_q[i] <= REG_RESET;
      end
    end else if (I_DEC_VALID && sel_postinc) begin
      // A write in the same cycle is dropped so that the pointer step is never lost.
      word_pointer_reg_q[low_word_pointer_reg] <=
        word_pointer_reg_q[low_word_pointer_reg] + size_bytes(op_size);
    end else if (I_REG_WE) begin
      word_pointer_reg_q[I_REG_NUM] <= I_REG_WDATA;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_VALID <= 1'b0;
    end else begin
      O_VALID <= I_DEC_VALID;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_IS_REG <= 1'b0;
      O_REG_SEL <= 3'h0;
      O_REG_LONG <= 1'b0;
    end else if (I_DEC_VALID) begin
      O_IS_REG <= sel_reg;
      O_REG_SEL <= reg_sel;
      O_REG_LONG <= reg_long;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MEM_ADDR <= 16'h0000;
      O_EXT_COUNT <= 2'h0;
      O_INSN_LEN <= 4'h0;
    end else if (I_DEC_VALID) begin
      O_MEM_ADDR <= mem_addr_d;
      O_EXT_COUNT <= ext_d;
      O_INSN_LEN <= len_d;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MODE_CYCLES <= 4'h0;
      O_REG_ACCESSES <= 2'h0;
      O_MEM_ACCESSES <= 3'h0;
    end else if (I_DEC_VALID) begin
      O_MODE_CYCLES <= modecyc_d;
      O_REG_ACCESSES <= racc_d;
      O_MEM_ACCESSES <= cor_accesses;
    end
  end

  // A wait pulse in a decode cycle belongs to the previous operand and is dropped.
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TOTAL_CYCLES <= 10'h000;
    end else if (I_DEC_VALID) begin
      O_TOTAL_CYCLES <= total_d;
    end else if (wait_hit) begin
      O_TOTAL_CYCLES <= O_TOTAL_CYCLES + 10'h001;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_FETCH_CYCLES <= 10'h000;
    end else if (I_DEC_VALID) begin
      O_FETCH_CYCLES <= 10'h000;
    end else if (fetch_hit) begin
      O_FETCH_CYCLES <= O_FETCH_CYCLES + 10'(fetch_step);
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_SIGN_EXTENDED_IMMEDIATE <= 16'h0000;
      O_IO_ADDR <= 24'h000000;
      O_VECTOR <= 8'h00;
      O_ACCUM_OPERAND <= 32'h00000000;
    end else if (I_DEC_VALID) begin
      O_SIGN_EXTENDED_IMMEDIATE <= sext_d;
      O_IO_ADDR <= io_addr_d;
      O_VECTOR <= vector_d;
      O_ACCUM_OPERAND <= accum_d;
    end
  end

endmodule : ea_decode_top

// File: verification/ea_decode_props.sv
`timescale 1ns/100ps
// ****
// Decode properties
// ****
module ea_decode_props
  import ea_decode_pkg::*;
#(
  parameter int unsigned NUM_REGS = 8
) (
  // Inputs seen
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_DEC_VALID,
  input wire logic [4:0] I_EA_CODE,
  input wire logic [1:0] I_OP_LOC,
  input wire logic [2:0] I_BASE_LEN,
  input wire logic [15:0] I_EXT_BYTES,
  input wire logic I_WAIT_CYCLE,
  input wire logic I_FETCH_STEP,
  // Outputs seen
  input wire logic O_VALID,
  input wire logic O_IS_REG,
  input wire logic [15:0] O_MEM_ADDR,
  input wire logic [1:0] O_EXT_COUNT,
  input wire logic [3:0] O_INSN_LEN,
  input wire logic [3:0] O_MODE_CYCLES,
  input wire logic [1:0] O_REG_ACCESSES,
  input wire logic [9:0] O_TOTAL_CYCLES,
  input wire logic [9:0] O_FETCH_CYCLES
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence s_take_reg;
    I_DEC_VALID && I_EA_CODE <= CODE_REG_LAST;
  endsequence
  // Waits only count between decodes, so the step is taken from the held total.
  sequence s_idle_wait;
    !I_DEC_VALID && I_WAIT_CYCLE && I_OP_LOC != 2'h0 && I_EA_CODE > CODE_REG_LAST;
  endsequence
  a_reg_direct: assert property (s_take_reg |=> O_IS_REG && O_MEM_ADDR == 16'h0000)
    else $error("register code gave memory result");
  a_mem_mode: assert property (I_DEC_VALID && I_EA_CODE >= CODE_IND_FIRST |=> O_VALID && !O_IS_REG)
    else $error("memory code gave register result");
  a_postinc_cost: assert property (I_DEC_VALID && I_EA_CODE[4:2] == 3'h3 |=>
    O_MODE_CYCLES == CYC_POSTINC && O_REG_ACCESSES == RACC_TWO && O_EXT_COUNT == EXT_NONE)
    else $error("post increment cost wrong");
  a_short_displacement_ext: assert property (I_DEC_VALID && I_EA_CODE[4:3] == 2'h2 |=>
    O_EXT_COUNT == EXT_ONE && O_MODE_CYCLES == CYC_PLAIN && O_REG_ACCESSES == RACC_ONE)
    else $error("short displacement cost wrong");
  a_direct_addr: assert property (I_DEC_VALID && I_EA_CODE == CODE_DIRECT |=>
    O_MEM_ADDR == $past(I_EXT_BYTES) && O_MODE_CYCLES == CYC_DIRECT && O_REG_ACCESSES == 2'h0)
    else $error("direct address wrong");
  a_insn_len: assert property (I_DEC_VALID |=>
    O_INSN_LEN == {1'h0, $past(I_BASE_LEN)} + {2'h0, O_EXT_COUNT})
    else $error("length wrong");
  a_wait_stretch: assert property (s_idle_wait |=>
    O_TOTAL_CYCLES == $past(O_TOTAL_CYCLES) + 10'h001)
    else $error("wait not counted");
  a_int_no_wait: assert property (!I_DEC_VALID && I_OP_LOC == 2'h0 |=>
    O_TOTAL_CYCLES == $past(O_TOTAL_CYCLES))
    else $error("internal operand total moved");
  a_fetch_int: assert property (!I_DEC_VALID && I_FETCH_STEP && I_OP_LOC == 2'h0 |=>
    O_FETCH_CYCLES == $past(O_FETCH_CYCLES) + {6'h00, FETCH_INT_WORD})
    else $error("fetch step wrong");
endmodule : ea_decode_props

bind ea_decode_top ea_decode_props #(.NUM_REGS(NUM_REGS)) props (.I_SYS_CLK, .I_RST,
  .I_DEC_VALID, .I_EA_CODE, .I_OP_LOC, .I_BASE_LEN, .I_EXT_BYTES, .I_WAIT_CYCLE,
  .I_FETCH_STEP, .O_VALID, .O_IS_REG, .O_MEM_ADDR, .O_EXT_COUNT, .O_INSN_LEN,
  .O_MODE_CYCLES, .O_REG_ACCESSES, .O_TOTAL_CYCLES, .O_FETCH_CYCLES);

// File: verification/bus_seq_model.sv
`timescale 1ns/100ps
// ****
// Ready and fetch source
// ****
module bus_seq_model (
  // Control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [3:0] i_waits,
  input wire logic [3:0] i_fetches,
  // Pulses
  output logic o_wait,
  output logic o_fetch
);
  logic [3:0] wait_q, fetch_q;
  // Waits come before fetches so that no two pulses share one cycle.
  assign o_wait = wait_q != 4'h0;
  assign o_fetch = !o_wait && fetch_q != 4'h0;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 4'h0;
      fetch_q <= 4'h0;
    end else if (i_go) begin
      wait_q <= i_waits;
      fetch_q <= i_fetches;
    end else if (o_wait) begin
      wait_q <= wait_q - 4'h1;
    end else if (o_fetch) begin
      fetch_q <= fetch_q - 4'h1;
    end
  end
endmodule : bus_seq_model

// File: verification/operand_address_decode_cycles_test.sv
`timescale 1ns/100ps
module operand_address_decode_cycles_test
  import ea_decode_pkg::*;
;
  logic clk = '0, rst = 1'h1, v = '0, we = '0, go = '0;
  logic [4:0] code = '0;
  logic [1:0] sz = '0, loc = '0;
  logic [2:0] rn = '0;
  logic [3:0] nw = '0, nf = '0;
  logic [15:0] ext = '0, pc = '0, wd = '0, seed = 16'h0031;
  logic [15:0] rw [8];
  logic [9:0] last_t;
  int errors = 0, total_checks = 0;
  // Side inputs follow the random extension word so one draw feeds all of them.
  wire logic [7:0] bcyc = ext[10:3], imm = ext[15:8], io = ext[7:0], vf = ext[11:4];
  wire logic wt, fs, o_v, o_r, o_l;
  wire logic [2:0] o_sel, o_ma;
  wire logic [15:0] o_a, o_sx;
  wire logic [1:0] o_x, o_ra;
  wire logic [3:0] o_n, o_mc;
  wire logic [9:0] o_t, o_f;
  wire logic [23:0] o_io;
  wire logic [7:0] o_vec;
  wire logic [31:0] o_acc;

  always #12.5 clk = ~clk;

  ea_decode_top dut (.I_SYS_CLK(clk), .I_RST(rst), .I_DEC_VALID(v), .I_EA_CODE(code),
    .I_OP_SIZE(sz), .I_OP_LOC(loc), .I_BASE_LEN(ext[2:0]), .I_BASE_CYCLES(bcyc),
    .I_EXT_BYTES(ext), .I_PC(pc), .I_BYTE_IMMEDIATE(imm), .I_IO_OFFSET(io),
    .I_VECTOR_FIELD(vf), .I_VECTOR_LONG(ext[8]), .I_ACCUM({ext, ~ext}), .I_REG_WE(we),
    .I_REG_NUM(rn), .I_REG_WDATA(wd), .I_WAIT_CYCLE(wt), .I_FETCH_STEP(fs),
    .O_VALID(o_v), .O_IS_REG(o_r), .O_REG_SEL(o_sel), .O_REG_LONG(o_l), .O_MEM_ADDR(o_a),
    .O_EXT_COUNT(o_x), .O_INSN_LEN(o_n), .O_MODE_CYCLES(o_mc), .O_REG_ACCESSES(o_ra),
    .O_MEM_ACCESSES(o_ma), .O_TOTAL_CYCLES(o_t), .O_SIGN_EXTENDED_IMMEDIATE(o_sx),
    .O_IO_ADDR(o_io), .O_VECTOR(o_vec), .O_ACCUM_OPERAND(o_acc), .O_FETCH_CYCLES(o_f));
  bus_seq_model seq (.i_clk(clk), .i_rst(rst), .i_go(go), .i_waits(nw), .i_fetches(nf),
    .o_wait(wt), .o_fetch(fs));

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step
  function automatic logic [3:0] mcyc(input logic [4:0] c);
    if (c[4:3] == 2'h0) return 4'h0;
    if (c[4:2] == 3'h3 || c[4:1] == 4'hE) return 4'h4;
    return c == 5'h1F ? 4'h1 : 4'h2;
  endfunction : mcyc
  function automatic logic [1:0] xcnt(input logic [4:0] c);
    if (c[4:3] == 2'h2) return 2'h1;
    return (c[4:2] == 3'h6 || c[4:1] == 4'hF) ? 2'h2 : 2'h0;
  endfunction : xcnt
  function automatic logic [6:0] cor(input logic [1:0] s, l, input logic odd);
    if (l == 2'h0 && !odd) return {4'h0, s == 2'h2 ? 3'h2 : 3'h1};
    if (l == 2'h0) return s == 2'h2 ? 7'h24 : s == 2'h1 ? 7'h12 : 7'h01;
    if (l == 2'h1 && !odd) return s == 2'h2 ? 7'h12 : 7'h09;
    return s == 2'h2 ? 7'h44 : s == 2'h1 ? 7'h22 : 7'h09;
  endfunction : cor
  function automatic logic [15:0] ea(input logic [4:0] c, input logic [15:0] x);
    case (c[4:2])
      3'h2, 3'h3: return rw[c[1:0]];
      3'h4, 3'h5: return rw[c[2:0]] + {{8{x[7]}}, x[7:0]};
      3'h6: return rw[c[1:0]] + x;
      default: return c[1] ? (c[0] ? x : pc + x) : rw[c[0]] + rw[7];
    endcase
  endfunction : ea

  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic dec(input logic [4:0] c, input logic [1:0] s, l);
    logic [15:0] a;
    logic [6:0] k;
    logic m;
    seed = step(seed);
    a = ea(c, seed);
    m = c > CODE_REG_LAST;
    k = cor(s, m ? l : 2'h0, m & a[0]);
    last_t = seed[10:3] + mcyc(c) + k[6:3];
    @(posedge clk);
    v <= 1'h1;
    code <= c;
    sz <= s;
    loc <= l;
    ext <= seed;
    @(posedge clk);
    v <= 1'h0;
    if (c[4:2] == 3'h3) rw[c[1:0]] = a + (s == 2'h0 ? 16'h1 : s == 2'h1 ? 16'h2 : 16'h4);
    @(negedge clk);
    check(o_v, 1'h1);
    check(o_r, !m);
    check(o_ma, k[2:0]);
    check(o_sx, {{8{seed[15]}}, seed[15:8]});
    check(o_io, {16'h0, seed[7:0]});
    check(o_vec, seed[8] ? seed[11:4] : {4'h0, seed[7:4]});
    check(o_acc, s == 2'h0 ? {24'h0, ~seed[7:0]} : s == 2'h1 ? {16'h0, ~seed} : {seed, ~seed});
    check(o_a, m ? a : 16'h0);
    check(o_x, xcnt(c));
    check(o_n, seed[2:0] + xcnt(c));
    check(o_mc, mcyc(c));
    check(o_ra, !m || c[4:1] == 4'hF ? 2'h0 : mcyc(c) == 4'h4 ? 2'h2 : 2'h1);
    check(o_t, last_t);
    if (!m) begin
      check(o_sel, s == 2'h2 ? {c[2:1], 1'h0} : c[2:0]);
      check(o_l, s == 2'h2);
    end
  endtask : dec

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    check(o_t, 10'h0);
    for (int i = 0; i < 8; i++) begin
      seed = step(seed);
      @(posedge clk);
      we <= 1'h1;
      rn <= i[2:0];
      wd <= seed;
      rw[i] = seed;
    end
    @(posedge clk);
    we <= 1'h0;
    pc <= seed;
    @(posedge clk);
    $display("test reset done");
    for (int p = 0; p < 192; p++) dec(p[4:0], 2'(p / 64), 2'(seed % 3));
    $display("test decode done");
    for (int l = 0; l < 3; l++) begin
      dec(5'h1F, 2'h1, l[1:0]);
      check(o_f, 10'h0);
      @(posedge clk);
      go <= 1'h1;
      nw <= seed[3:0] | 4'h1;
      nf <= seed[7:4] | 4'h1;
      @(posedge clk);
      go <= 1'h0;
      repeat (40) @(posedge clk);
      @(negedge clk);
      check(o_v, 1'h0);
      check(o_t, last_t + (l == 0 ? 10'h0 : {6'h0, nw}));
      check(o_f, nf * (l == 0 ? 10'h2 : 10'h3));
    end
    $display("test waits done");
    summarize();
  end
endmodule : operand_address_decode_cycles_test
